// ---- src/tuner_synth_consts.svh ----
`ifndef TUNER_SYNTH_CONSTS_SVH
`define TUNER_SYNTH_CONSTS_SVH
// fixed upper address bits, direction encoding
`define ADDR_FIXED    5'h18
`define DIR_READ      1'b1
// bit counting within a byte
`define BYTE_BITS     4'h8
`define LAST_TX_BIT   4'h7
// leading bit of the first byte of a pair
`define LEAD_DIVIDER  1'b0
// write byte field positions
`define LEAD_BIT      7
`define UPPER_FIELD   6:0
`define PUMP_FIELD    6:5
`define RATIO_FIELD   4:0
`define PASS_BIT      7
`define BAND_FIELD    6:5
`define TEST_EN_BIT   4
`define PORT_FIELD    3:0
// reset values
`define DIV_RST       15'h0000
`define UPPER_RST     7'h00
`define RATIO_RST     5'h00
`define PUMP_RST      2'h0
`define BAND_RST      2'h0
`define PORT_RST      4'h0
`define POR_RST       1'b1
`define STATUS_PAD    6'h00
// test code decoding
`define TEST_FPD      3'h4
`define TEST_SINK     2'h1
`define TEST_SOURCE   2'h2
`define TEST_PUMP_OFF 2'h3
`define TEST_NONE     2'h0
// reference ratio decoding
`define RATIO_BASE    9'h002
`define RATIO_MULT0   9'h004
`define RATIO_BAD     9'h000
`endif

// ---- src/tuner_synth_pkg.sv ----
package tuner_synth_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK,
		ST_RD_NEXT,
		ST_IGNORE
	} link_state_e;
endpackage

// ---- src/tuner_synth_serial_control.sv ----
// Operation
// - accept standard and fast two-wire transfers
// - address lsb low writes, high reads
// - match 11000 plus two select bits
// - acknowledge matched address and every data byte
// - status nack makes internal stop
// - first byte lead bit picks divider/control pair
// - keep taking pairs until stop
// - partial byte at stop is discarded
// - divider applied after fifteen bits or stop
// - divider bits 14-8 then 7-0
// - control byte: lead, pump code, ratio
// - ratio code decodes to division ratio
// - second control: passband, band, test, ports
// - band bits choose oscillator band
// - ports on at 1, off after power-up
// - test enable puts test code on ports
// - test codes force pump and lock flag
// - test code routes signal to lowest port
// - status: power-fail, lock, six zeros
// - power-fail set on drop, cleared by read stop
// - lock flag follows loop lock
// - halved divider and comparison only via test
`timescale 1ns/100ps
`include "tuner_synth_consts.svh"
module tuner_synth_serial_control
	import tuner_synth_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rstn,
	// loop divider output, a clock of its own
	input  wire logic        fpd_clk,
	// two-wire bus
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// analog side status
	input  wire logic [1:0]  addr_level,
	input  wire logic        pll_locked,
	input  wire logic        supply_low,
	input  wire logic        fcomp,
	// synthesizer settings
	output logic [14:0]      divider_word,
	output logic [4:0]       ref_ratio_code,
	output logic [8:0]       ref_ratio_value,
	output logic             ref_ratio_bad,
	output logic [1:0]       pump_current_code,
	output logic [1:0]       band_choice,
	output logic             passband_select,
	output logic             test_enable,
	output logic [2:0]       test_code,
	// charge pump test overrides
	output logic             pump_sink,
	output logic             pump_source,
	output logic             pump_off,
	// switching ports, 1 = on
	output logic [3:0]       port_outputs
);
	function automatic logic [8:0] ratio_of(input logic [4:0] c);
		logic [8:0] m;
		m = {7'h00, c[4:3]} + `RATIO_MULT0;
		if (c[4:3] == 2'h0) begin
			ratio_of = `RATIO_BASE << c[2:0];
		end else if (c[2:0] == 3'h0) begin
			ratio_of = `RATIO_BAD;
		end else begin
			ratio_of = m << (c[2:0] - 3'h1);
		end
	endfunction

	logic [7:0]   in_s1_reg;
	logic [7:0]   in_s2_reg;
	logic         scl_d_reg;
	logic         sda_d_reg;
	logic         scl_s;
	logic         sda_s;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_cond;
	logic         stop_cond;
	logic         power_drop;
	logic         addr_match;
	logic         byte_done;
	link_state_e  state_reg;
	logic [3:0]   bit_cnt_reg;
	logic [7:0]   shift_reg;
	logic [7:0]   tx_reg;
	logic         sda_drive_reg;
	logic         read_mode_reg;
	logic         read_session_reg;
	logic         pair_second_reg;
	logic         pair_div_reg;
	logic [6:0]   upper_shadow_reg;
	logic         upper_pending_reg;
	logic [14:0]  divider_reg;
	logic [4:0]   ratio_reg;
	logic [1:0]   pump_reg;
	logic [1:0]   band_reg;
	logic         pass_reg;
	logic         te_reg;
	logic [3:0]   port_reg;
	logic         por_reg;
	logic         lock_reg;
	logic [7:0]   status_byte;
	logic [1:0]   test_low;
	logic         fpd_sel_reg;
	logic         fpd_en1_reg;
	logic         fpd_en2_reg;
	logic         fpd_half_reg;
	logic [8:0]   ratio_value_reg;
	logic [3:0]   port_out_reg;
	logic [2:0]   pump_test_reg;

	// every pin passes two flops; the half-rate divider bit also crosses here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_s1_reg <= 8'h03;
			in_s2_reg <= 8'h03;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			in_s1_reg <= {fpd_half_reg, fcomp, supply_low, pll_locked, addr_level, sda_in, scl};
			in_s2_reg <= in_s1_reg;
			scl_d_reg <= in_s2_reg[0];
			sda_d_reg <= in_s2_reg[1];
		end
	end

	// oversampling at 200 MHz covers both bus speeds
	assign scl_s      = in_s2_reg[0];
	assign sda_s      = in_s2_reg[1];
	assign scl_rise   = scl_s & ~scl_d_reg;
	assign scl_fall   = ~scl_s & scl_d_reg;
	assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign power_drop = in_s2_reg[5];
	assign addr_match = (shift_reg[7:3] == `ADDR_FIXED) && (shift_reg[2:1] == in_s2_reg[3:2]);
	assign byte_done  = (state_reg == ST_WR) && scl_fall && (bit_cnt_reg == `BYTE_BITS);
	assign status_byte = {por_reg, lock_reg, `STATUS_PAD};
	assign sda_out    = 1'b0;
	assign sda_oe     = sda_drive_reg;

	// bus protocol
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg        <= ST_IDLE;
			bit_cnt_reg      <= 4'h0;
			shift_reg        <= 8'h00;
			tx_reg           <= 8'h00;
			sda_drive_reg    <= 1'b0;
			read_mode_reg    <= 1'b0;
			read_session_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg        <= ST_ADDR;
			bit_cnt_reg      <= 4'h0;
			sda_drive_reg    <= 1'b0;
			read_session_reg <= 1'b0;
		end else if (stop_cond) begin
			// a partial byte simply dies with the state change
			state_reg        <= ST_IDLE;
			sda_drive_reg    <= 1'b0;
			read_session_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR, ST_WR: begin
					if (scl_rise && bit_cnt_reg != `BYTE_BITS) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					if (scl_fall && bit_cnt_reg == `BYTE_BITS) begin
						if (state_reg == ST_WR) begin
							state_reg     <= ST_WR_ACK;
							sda_drive_reg <= 1'b1;
						end else if (addr_match) begin
							state_reg        <= ST_ADDR_ACK;
							sda_drive_reg    <= 1'b1;
							read_mode_reg    <= shift_reg[0] == `DIR_READ;
							read_session_reg <= shift_reg[0] == `DIR_READ;
						end else begin
							state_reg <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK, ST_WR_ACK, ST_RD_NEXT: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (read_mode_reg) begin
							state_reg     <= ST_RD;
							tx_reg        <= status_byte;
							sda_drive_reg <= ~status_byte[7];
						end else begin
							state_reg     <= ST_WR;
							sda_drive_reg <= 1'b0;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bit_cnt_reg == `LAST_TX_BIT) begin
							state_reg     <= ST_RD_ACK;
							sda_drive_reg <= 1'b0;
						end else begin
							bit_cnt_reg   <= bit_cnt_reg + 4'h1;
							tx_reg        <= {tx_reg[6:0], 1'b0};
							sda_drive_reg <= ~tx_reg[6];
						end
					end
				end
				ST_RD_ACK: begin
					// controller low means one more status byte
					if (scl_rise) begin
						state_reg <= sda_s ? ST_IGNORE : ST_RD_NEXT;
					end
				end
				default: begin
					sda_drive_reg <= 1'b0;
				end
			endcase
		end
	end

	// write byte decoding; a supply drop restores power-up values
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pair_second_reg   <= 1'b0;
			pair_div_reg      <= 1'b0;
			upper_shadow_reg  <= `UPPER_RST;
			upper_pending_reg <= 1'b0;
			divider_reg       <= `DIV_RST;
			ratio_reg         <= `RATIO_RST;
			pump_reg          <= `PUMP_RST;
			band_reg          <= `BAND_RST;
			pass_reg          <= 1'b0;
			te_reg            <= 1'b0;
			port_reg          <= `PORT_RST;
		end else if (power_drop) begin
			pair_second_reg   <= 1'b0;
			pair_div_reg      <= 1'b0;
			upper_shadow_reg  <= `UPPER_RST;
			upper_pending_reg <= 1'b0;
			divider_reg       <= `DIV_RST;
			ratio_reg         <= `RATIO_RST;
			pump_reg          <= `PUMP_RST;
			band_reg          <= `BAND_RST;
			pass_reg          <= 1'b0;
			te_reg            <= 1'b0;
			port_reg          <= `PORT_RST;
		end else begin
			if (state_reg == ST_ADDR_ACK) begin
				pair_second_reg <= 1'b0;
			end
			if (byte_done && !pair_second_reg) begin
				pair_second_reg <= 1'b1;
				pair_div_reg    <= shift_reg[`LEAD_BIT] == `LEAD_DIVIDER;
				if (shift_reg[`LEAD_BIT] == `LEAD_DIVIDER) begin
					// held until the low byte lands; a stop applies it alone over the old low byte
					upper_shadow_reg  <= shift_reg[`UPPER_FIELD];
					upper_pending_reg <= 1'b1;
				end else begin
					pump_reg  <= shift_reg[`PUMP_FIELD];
					ratio_reg <= shift_reg[`RATIO_FIELD];
				end
			end else if (byte_done) begin
				pair_second_reg <= 1'b0;
				if (pair_div_reg) begin
					divider_reg       <= {upper_shadow_reg, shift_reg};
					upper_pending_reg <= 1'b0;
				end else begin
					pass_reg <= shift_reg[`PASS_BIT];
					band_reg <= shift_reg[`BAND_FIELD];
					te_reg   <= shift_reg[`TEST_EN_BIT];
					port_reg <= shift_reg[`PORT_FIELD];
				end
			end else if (stop_cond && upper_pending_reg) begin
				divider_reg[14:8] <= upper_shadow_reg;
				upper_pending_reg <= 1'b0;
			end
		end
	end

	// power-fail flag: a drop in the same cycle as the clearing stop wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			por_reg <= `POR_RST;
		end else if (power_drop) begin
			por_reg <= 1'b1;
		end else if (stop_cond && read_session_reg) begin
			por_reg <= 1'b0;
		end
	end

	// test code lives in the upper port bits, so port data is lost under test
	// low two test code bits sit in port bits 2:1, port bit 0 is never part of the code
	assign test_low = te_reg ? port_reg[2:1] : `TEST_NONE;

	// lock flag and pump overrides
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_reg      <= 1'b0;
			pump_test_reg <= 3'h0;
		end else begin
			pump_test_reg <= {test_low == `TEST_PUMP_OFF, test_low == `TEST_SOURCE, test_low == `TEST_SINK};
			if (test_low == `TEST_PUMP_OFF) begin
				lock_reg <= 1'b1;
			end else if (test_low != `TEST_NONE) begin
				lock_reg <= 1'b0;
			end else begin
				lock_reg <= in_s2_reg[4];
			end
		end
	end

	// port drive and ratio decode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_out_reg    <= `PORT_RST;
			ratio_value_reg <= `RATIO_BAD;
			fpd_sel_reg     <= 1'b0;
		end else begin
			fpd_sel_reg     <= te_reg && (port_reg[3:1] == `TEST_FPD);
			ratio_value_reg <= ratio_of(ratio_reg);
			port_out_reg[3:1] <= port_reg[3:1];
			if (te_reg && port_reg[3]) begin
				port_out_reg[0] <= (port_reg[2:1] == 2'h0) ? in_s2_reg[7] : in_s2_reg[6];
			end else begin
				port_out_reg[0] <= port_reg[0];
			end
		end
	end

	// halved divider output, run only while selected
	always_ff @(posedge fpd_clk or negedge rstn) begin
		if (!rstn) begin
			fpd_en1_reg  <= 1'b0;
			fpd_en2_reg  <= 1'b0;
			fpd_half_reg <= 1'b0;
		end else begin
			fpd_en1_reg  <= fpd_sel_reg;
			fpd_en2_reg  <= fpd_en1_reg;
			fpd_half_reg <= fpd_en2_reg ? ~fpd_half_reg : 1'b0;
		end
	end

	assign divider_word      = divider_reg;
	assign ref_ratio_code    = ratio_reg;
	assign ref_ratio_value   = ratio_value_reg;
	assign ref_ratio_bad     = ratio_value_reg == `RATIO_BAD;
	assign pump_current_code = pump_reg;
	assign band_choice       = band_reg;
	assign passband_select   = pass_reg;
	assign test_enable       = te_reg;
	assign test_code         = port_reg[3:1];
	assign pump_sink         = pump_test_reg[0];
	assign pump_source       = pump_test_reg[1];
	assign pump_off          = pump_test_reg[2];
	assign port_outputs      = port_out_reg;

	property p_addr_ack;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ST_ADDR && scl_fall && bit_cnt_reg == `BYTE_BITS && addr_match && !start_cond && !stop_cond)
			|=> sda_oe && state_reg == ST_ADDR_ACK;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("matched address not acknowledged");

	property p_addr_miss;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ST_ADDR && scl_fall && bit_cnt_reg == `BYTE_BITS && !addr_match && !start_cond && !stop_cond)
			|=> !sda_oe && state_reg == ST_IGNORE;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

	property p_direction;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ST_ADDR && scl_fall && bit_cnt_reg == `BYTE_BITS && addr_match && !start_cond && !stop_cond)
			|=> read_mode_reg == $past(shift_reg[0]);
	endproperty
	a_direction: assert property (p_direction) else $error("direction bit not taken");

	property p_div_word;
		@(posedge clk) disable iff (!rstn)
		(byte_done && pair_second_reg && pair_div_reg && !power_drop && !start_cond && !stop_cond)
			|=> divider_word == {$past(upper_shadow_reg), $past(shift_reg)};
	endproperty
	a_div_word: assert property (p_div_word) else $error("divider word misassembled");

	property p_div_hold;
		@(posedge clk) disable iff (!rstn)
		(byte_done && !pair_second_reg && !shift_reg[7] && !power_drop && !start_cond && !stop_cond)
			|=> $stable(divider_word) && upper_pending_reg;
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("upper divider byte applied early");

	property p_stop_apply;
		@(posedge clk) disable iff (!rstn)
		(stop_cond && upper_pending_reg && !power_drop) |=> divider_word[14:8] == $past(upper_shadow_reg);
	endproperty
	a_stop_apply: assert property (p_stop_apply) else $error("stop did not apply divider");

	property p_ctrl_byte;
		@(posedge clk) disable iff (!rstn)
		(byte_done && !pair_second_reg && shift_reg[7] && !power_drop && !start_cond && !stop_cond)
			|=> ref_ratio_code == $past(shift_reg[4:0]) && pump_current_code == $past(shift_reg[6:5]);
	endproperty
	a_ctrl_byte: assert property (p_ctrl_byte) else $error("control byte fields wrong");

	property p_lock_off;
		@(posedge clk) disable iff (!rstn)
		(te_reg && port_reg[2:1] == `TEST_PUMP_OFF) [*2] |-> lock_reg && pump_off && !pump_sink;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("pump-off test mode wrong");

	property p_status_msb;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ST_ADDR_ACK && read_mode_reg && scl_fall && !start_cond && !stop_cond)
			|=> sda_oe == !$past(por_reg) && tx_reg[5:0] == `STATUS_PAD;
	endproperty
	a_status_msb: assert property (p_status_msb) else $error("status byte start wrong");

	property p_por_clear;
		@(posedge clk) disable iff (!rstn)
		(stop_cond && read_session_reg && !power_drop) |=> !por_reg;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("power-fail not cleared");

	property p_nack_stop;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ST_RD_ACK && scl_rise && sda_s && !start_cond && !stop_cond)
			|=> state_reg == ST_IGNORE ##1 !sda_oe;
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("read continued after nack");

	property p_fpd_idle;
		@(posedge fpd_clk) disable iff (!rstn)
		!fpd_en2_reg |=> !fpd_half_reg;
	endproperty
	a_fpd_idle: assert property (p_fpd_idle) else $error("halved divider runs unselected");
endmodule

// ---- test/bus_ctrl_model.sv ----
`timescale 1ns/100ps
module bus_ctrl_model (
	// system
	input  wire logic clk,
	// two-wire bus, sda already resolved with its pull-up
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	// clocks per half bus period; 250 is fast mode, shorter runs keep the bench quick
	int half = 30;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic hw();
		repeat (half) @(posedge clk);
	endtask

	// also serves as repeated start: sda is released before scl rises
	task automatic start();
		@(posedge clk);
		sda_drv <= 1'b1;
		hw();
		scl <= 1'b1;
		hw();
		sda_drv <= 1'b0;
		hw();
		scl <= 1'b0;
	endtask

	task automatic stop();
		@(posedge clk);
		sda_drv <= 1'b0;
		hw();
		scl <= 1'b1;
		hw();
		sda_drv <= 1'b1;
		hw();
	endtask

	// data moves one edge after scl falls so it never looks like start or stop
	task automatic wr_bits(input logic [7:0] b, input int n, output logic ack);
		ack = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			sda_drv <= b[7-i];
			hw();
			scl <= 1'b1;
			hw();
			scl <= 1'b0;
		end
		if (n == 8) begin
			@(posedge clk);
			sda_drv <= 1'b1;
			hw();
			scl <= 1'b1;
			hw();
			ack = !sda;
			scl <= 1'b0;
		end
	endtask

	task automatic rd_byte(input logic ack_it, output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			sda_drv <= 1'b1;
			hw();
			scl <= 1'b1;
			hw();
			b = {b[6:0], sda};
			scl <= 1'b0;
		end
		@(posedge clk);
		sda_drv <= !ack_it;
		hw();
		scl <= 1'b1;
		hw();
		scl <= 1'b0;
		@(posedge clk);
		sda_drv <= 1'b1;
	endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	import tuner_synth_pkg::*;
	logic        clk;
	logic        rstn;
	logic        fpd_clk;
	logic        scl;
	logic        sda_drv;
	logic        sda_out;
	logic        sda_oe;
	logic [1:0]  addr_level;
	logic        pll_locked;
	logic        supply_low;
	logic        fcomp;
	logic [14:0] divider_word;
	logic [4:0]  ref_ratio_code;
	logic [8:0]  ref_ratio_value;
	logic        ref_ratio_bad;
	logic [1:0]  pump_current_code;
	logic [1:0]  band_choice;
	logic        passband_select;
	logic        test_enable;
	logic [2:0]  test_code;
	logic        pump_sink;
	logic        pump_source;
	logic        pump_off;
	logic [3:0]  port_outputs;
	int          fail_count = 0;
	int          checks_done = 0;
	logic [14:0] exp_div;
	logic [7:0]  c1;
	logic [7:0]  c2;
	logic        por;
	logic [7:0]  b;
	logic        ack;
	int          n;

	// open drain: the device only ever pulls low, the pull-up gives the high level
	wire sda_line = sda_drv && !(sda_oe && (sda_out == 1'b0));

	tuner_synth_serial_control u_tuner_synth_serial_control (.clk(clk), .rstn(rstn), .fpd_clk(fpd_clk),
		.scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_level(addr_level),
		.pll_locked(pll_locked), .supply_low(supply_low), .fcomp(fcomp), .divider_word(divider_word),
		.ref_ratio_code(ref_ratio_code), .ref_ratio_value(ref_ratio_value), .ref_ratio_bad(ref_ratio_bad),
		.pump_current_code(pump_current_code), .band_choice(band_choice), .passband_select(passband_select),
		.test_enable(test_enable), .test_code(test_code), .pump_sink(pump_sink), .pump_source(pump_source),
		.pump_off(pump_off), .port_outputs(port_outputs));
	bus_ctrl_model u_bus_ctrl_model (.clk(clk), .sda(sda_line), .scl(scl), .sda_drv(sda_drv));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// divider output clock, phase unrelated to clk
	initial begin
		fpd_clk = 1'b0;
		#1.3;
		forever #80 fpd_clk = ~fpd_clk;
	end
	initial begin
		fcomp = 1'b0;
		forever begin
			repeat (16) @(posedge clk);
			fcomp <= ~fcomp;
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [8:0] ratio(input logic [4:0] c);
		if (c[4:3] == 2'h0)
			return 9'h002 << c[2:0];
		if (c[2:0] == 3'h0)
			return 9'h000;
		return 9'(4 + c[4:3]) << (c[2:0] - 1);
	endfunction

	function automatic logic lock_exp();
		if (c2[4] && c2[2:1] != 2'h0)
			return c2[2:1] == 2'h3;
		return pll_locked;
	endfunction

	function automatic int bucket(input int k);
		if (k == 0)
			return 0;
		if (k >= 6 && k <= 10)
			return 1;
		if (k >= 13 && k <= 19)
			return 2;
		return 3;
	endfunction

	task automatic addr(input logic rw, input logic ok);
		u_bus_ctrl_model.start();
		u_bus_ctrl_model.wr_bits({5'h18, addr_level, rw}, 8, ack);
		check(ack, ok);
	endtask

	task automatic wb(input logic [7:0] v);
		u_bus_ctrl_model.wr_bits(v, 8, ack);
		check(ack, 1'b1);
	endtask

	task automatic rd_status();
		addr(1'b1, 1'b1);
		u_bus_ctrl_model.rd_byte(1'b0, b);
		u_bus_ctrl_model.stop();
		check(b, {por, lock_exp(), 6'h00});
		por = 1'b0;
	endtask

	task automatic check_cfg();
		check(divider_word, exp_div);
		check(ref_ratio_code, c1[4:0]);
		check(ref_ratio_value, ratio(c1[4:0]));
		check(ref_ratio_bad, ratio(c1[4:0]) == 9'h000);
		check(pump_current_code, c1[6:5]);
		check({passband_select, band_choice, test_enable, test_code}, c2[7:1]);
		check(port_outputs[3:1], c2[3:1]);
		if (!(c2[4] && c2[3]))
			check(port_outputs[0], c2[0]);
		check({pump_sink, pump_source, pump_off}, c2[4] ? 3'(4 >> (c2[2:1] - 1)) & {3{c2[2:1] != 2'h0}} : 3'h0);
		n = 0;
		b[0] = port_outputs[0];
		repeat (256) begin
			@(posedge clk);
			if (port_outputs[0] !== b[0])
				n++;
			b[0] = port_outputs[0];
		end
		check(bucket(n), (c2[4] && c2[3]) ? ((c2[2:1] == 2'h0) ? 1 : 2) : 0);
	endtask

	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		$display("timeout at %0t", $time);
		report_and_stop();
	end

	initial begin
		rstn = 1'b0;
		addr_level = 2'b01;
		pll_locked = 1'b1;
		supply_low = 1'b0;
		exp_div = 15'h0000;
		c1 = 8'h00;
		c2 = 8'h00;
		por = 1'b1;
		void'($urandom(53));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		check_cfg();
		u_bus_ctrl_model.half = 250;
		rd_status();
		u_bus_ctrl_model.half = 30;
		// continue on ack, then a refused byte after the controller's nack
		addr(1'b1, 1'b1);
		u_bus_ctrl_model.rd_byte(1'b1, b);
		check(b, 8'h40);
		u_bus_ctrl_model.rd_byte(1'b0, b);
		check(b, 8'h40);
		u_bus_ctrl_model.rd_byte(1'b0, b);
		check(b, 8'hff);
		u_bus_ctrl_model.stop();
		for (int s = 0; s < 4; s++) begin
			addr_level <= 2'(s);
			repeat (4) @(posedge clk);
			for (int a = 0; a < 5; a++) begin
				u_bus_ctrl_model.start();
				u_bus_ctrl_model.wr_bits({(a == 4) ? 5'h19 : 5'h18, 2'(s ^ a), 1'b0}, 8, ack);
				check(ack, a == 0);
				u_bus_ctrl_model.stop();
			end
		end
		addr_level <= 2'b01;
		// divider waits in its shadow until the low byte or a stop
		addr(1'b0, 1'b1);
		wb(8'h5a);
		repeat (4) @(posedge clk);
		check(divider_word, exp_div);
		wb(8'hc3);
		repeat (4) @(posedge clk);
		exp_div = 15'h5ac3;
		check(divider_word, exp_div);
		wb(8'h21);
		u_bus_ctrl_model.stop();
		exp_div = 15'h21c3;
		check(divider_word, exp_div);
		addr(1'b0, 1'b1);
		u_bus_ctrl_model.wr_bits(8'h80, 4, ack);
		u_bus_ctrl_model.stop();
		check_cfg();
		for (int it = 0; it < 8; it++) begin
			pll_locked <= 1'($urandom);
			addr(1'b0, 1'b1);
			repeat (1 + $urandom % 3) begin
				if (($urandom % 2) == 1) begin
					exp_div = 15'($urandom);
					wb({1'b0, exp_div[14:8]});
					wb(exp_div[7:0]);
				end else begin
					// occasional forbidden ratio codes are sent on purpose
					c1 = {1'b1, 7'($urandom)};
					c2 = 8'($urandom);
					wb(c1);
					wb(c2);
				end
			end
			u_bus_ctrl_model.stop();
			repeat (8) @(posedge clk);
			check_cfg();
			rd_status();
		end
		supply_low <= 1'b1;
		repeat (10) @(posedge clk);
		supply_low <= 1'b0;
		repeat (6) @(posedge clk);
		exp_div = 15'h0000;
		c1 = 8'h00;
		c2 = 8'h00;
		por = 1'b1;
		check_cfg();
		rd_status();
		report_and_stop();
	end
endmodule
